// file: inc/mxt_pkg.sv
package mxt_pkg;
    localparam int POS_W = 16;
    localparam logic [POS_W-1:0] POS_ZERO = 16'h0000;
    localparam logic [POS_W-1:0] POS_FULL = 16'hFFFF;
    localparam logic [POS_W-1:0] POS_HALF = 16'h8000;
    localparam int SRC_W = 6;
    localparam int RATE_W = 10;
    localparam int NKEY = 4;
    localparam int NDSK = 3;
    localparam int ORD_W = 8;
    localparam int NPVW = 6;
    // Element buttons: background, keys 1 to 4, layer order.
    localparam int NEL = 6;
    localparam int EL_BKGD = 0;
    localparam int EL_KEY = 1;
    localparam int EL_ORDER = 5;
    // Transition type buttons: mix, wipe, custom.
    localparam int NTT = 3;
    // Bit positions inside the synchronised button vector.
    localparam int BI_EL = 0;
    localparam int BI_TT = 6;
    localparam int BI_CUT = 9;
    localparam int BI_AUTO = 10;
    localparam int BI_BLK = 11;
    localparam int BI_REH = 12;
    localparam int BI_KMX = 13;
    localparam int BI_PVW = 17;
    localparam int BI_APR = 23;
    localparam int BI_BPR = 24;
    localparam int BI_RCL = 25;
    localparam int BTN_W = 26;
    // Video frame period and clock period; the frame rate is a plain default.
    localparam int FRAME_US = 33367;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FRAME_CYC = FRAME_US * 1000 / CLK_PERIOD_NS;
    localparam int CUT_LAMP_FRAMES = 6;
    localparam int CUT_W = 3;
    typedef enum logic [1:0] {TT_MIX, TT_WIPE, TT_USER} mxt_ttype_t;
    typedef enum logic [2:0] {PV_PRIMARY, PV_ME1, PV_ME2, PV_ME3, PV_PGM_A, PV_PGM_B} mxt_pvw_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LEVER, ST_AUTO, ST_PAUSE} mxt_run_t;
endpackage

// file: logic/mxt_prog.sv
`timescale 1ns/100ps
// Progress register: unsigned fixed point from zero to full scale.
module mxt_prog
    import mxt_pkg::*;
#(
    parameter int PW = POS_W,
    parameter int RW = RATE_W
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic frame_en_i,
    input wire logic load_i,
    input wire logic [PW-1:0] load_pos_i,
    input wire logic run_i,
    input wire logic [RW-1:0] rate_i,
    output logic [PW-1:0] pos_o,
    output logic done_o
);
    typedef struct packed {
        logic [PW-1:0] pos;
        logic done;
    } mxt_prog_st_t;

    mxt_prog_st_t q;
    mxt_prog_st_t d;
    logic [PW-1:0] step;
    logic [PW-1:0] rem;

    // A constant step per frame means a partly advanced position needs
    // proportionally fewer frames to finish.
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        step = PW'(POS_FULL / ((rate_i == '0) ? RW'(1) : rate_i));
        rem = POS_FULL - q.pos;
        if (load_i)
        begin
            d.pos = load_pos_i;
        end
        else if (run_i && frame_en_i)
        begin
            if (rem <= step)
            begin
                d.pos = POS_FULL;
                d.done = 1'b1;
            end
            else
            begin
                d.pos = q.pos + step;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign pos_o = q.pos;
    assign done_o = q.done;
endmodule // mxt_prog

// file: logic/mxt_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - Switched preview holds one of six choices, routes it, lights it high.
// - Primary crosspoint is high tally only when delegated and primary is chosen.
// - Stage has one main transition plus four separate keyer mix transitions.
// - Single element press selects only it; press while holding adds it.
// - Element selection never alters output; unselected elements keep state.
// - Background transition swaps A and B so A stays on air.
// - Key on lamps show the logical key state, not visibility.
// - Layer-order element moves key stacking to operator's new order.
// - Linked downstream keyers follow the transition; link is not recalled.
// - Mix, wipe and custom are exclusive and do not change output.
// - Cut applies selected changes instantly and flashes its lamp.
// - Auto runs lit; second press freezes; third press resumes, far lever limit completes.
// - Lever drives progress; far limit completes, return home abandons.
// - Out-of-step lever is ignored until resynced; arrows show direction.
// - Through-black toggles on each press outside rehearsal and lights while active.
// - Through-black takes two commands; black stage low-tallies A and B.
// - At black, type, keys and B source may change; key lamps preview.
// - Second through-black press cancels; at black returns original signal.
// - A bus press during through-black cancels it, airs source keyless.
// - Rehearsal refused off limit, during auto, or with through-black.
// - Rehearsal sends transition only to preview; program stays unchanged.
// - Lit rehearsal press cancels and aborts auto; end-off is configurable.
// - Key mix ignored during a main transition, allowed when merely selected.
// - Auto from a part-moved lever finishes in proportionally less time.
module mxt_ctrl
    import mxt_pkg::*;
#(
    parameter int FRAME_CYCLES = FRAME_CYC
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [NEL-1:0] elem_btn_i,
    input wire logic [NTT-1:0] type_btn_i,
    input wire logic cut_btn_i,
    input wire logic auto_btn_i,
    input wire logic black_btn_i,
    input wire logic rehearse_btn_i,
    input wire logic [NKEY-1:0] key_mix_btn_i,
    input wire logic [NPVW-1:0] pvw_btn_i,
    input wire logic a_press_i,
    input wire logic [SRC_W-1:0] a_src_i,
    input wire logic b_press_i,
    input wire logic [SRC_W-1:0] b_src_i,
    input wire logic recall_i,
    input wire logic [POS_W-1:0] lever_pos_i,
    input wire logic pvw_delegated_i,
    input wire logic [NDSK-1:0] dsk_link_i,
    input wire logic reh_auto_off_i,
    input wire logic [ORD_W-1:0] new_key_order_i,
    input wire logic [RATE_W-1:0] rate_frames_i,
    output logic [NPVW-1:0] pvw_lamp_o,
    output logic [2:0] pvw_route_o,
    output logic primary_xpt_high_o,
    output logic [NEL-1:0] elem_lamp_o,
    output logic [NTT-1:0] type_lamp_o,
    output logic cut_lamp_o,
    output logic auto_lamp_o,
    output logic black_lamp_o,
    output logic rehearse_lamp_o,
    output logic [NKEY-1:0] key_on_lamp_o,
    output logic [NKEY-1:0] key_mix_go_o,
    output logic arrow_up_o,
    output logic arrow_dn_o,
    output logic [SRC_W-1:0] a_src_o,
    output logic [SRC_W-1:0] b_src_o,
    output logic ab_low_tally_o,
    output logic pgm_black_o,
    output logic [NKEY-1:0] key_state_o,
    output logic [ORD_W-1:0] key_order_o,
    output logic [NDSK-1:0] dsk_on_o,
    output logic [POS_W-1:0] pgm_pos_o,
    output logic [POS_W-1:0] pvw_pos_o,
    output logic pvw_override_o,
    output logic complete_o
);
    localparam int DW = $clog2(FRAME_CYCLES + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(FRAME_CYCLES - 1);

    typedef struct packed {
        logic [BTN_W-1:0] b1;
        logic [BTN_W-1:0] b2;
        logic [BTN_W-1:0] b3;
        logic [SRC_W-1:0] as1;
        logic [SRC_W-1:0] as2;
        logic [SRC_W-1:0] bs1;
        logic [SRC_W-1:0] bs2;
        logic [POS_W-1:0] lv1;
        logic [POS_W-1:0] lv2;
        logic lv_off;
        logic [DW-1:0] div;
        logic frame;
        mxt_pvw_t pvw;
        logic [NEL-1:0] sel;
        mxt_ttype_t ttype;
        logic [SRC_W-1:0] a_src;
        logic [SRC_W-1:0] b_src;
        logic [NKEY-1:0] key_on;
        logic [ORD_W-1:0] key_order;
        logic [NDSK-1:0] dsk_on;
        mxt_run_t st;
        logic home;
        logic sync;
        logic blk_armed;
        logic blk_stage;
        logic reh;
        logic [CUT_W-1:0] cut_cnt;
        logic complete;
        logic [NKEY-1:0] kmx_go;
    } mxt_st_t;

    mxt_st_t q;
    mxt_st_t d;
    logic [BTN_W-1:0] btn_raw;
    logic [BTN_W-1:0] rise;
    logic [POS_W-1:0] pos;
    logic prog_done;
    logic prog_load;
    logic [POS_W-1:0] prog_ld_pos;
    logic lat_lo;
    logic lat_hi;
    logic at_home;
    logic at_far;

    assign btn_raw = {recall_i, b_press_i, a_press_i, pvw_btn_i, key_mix_btn_i,
                      rehearse_btn_i, black_btn_i, auto_btn_i, cut_btn_i,
                      type_btn_i, elem_btn_i};

    // Ends a main transition: the first stage of through-black only goes to
    // black; rehearsal never touches program state.
    function automatic mxt_st_t finish(input mxt_st_t s, input logic auto_off,
                                       input logic [ORD_W-1:0] ord,
                                       input logic [NDSK-1:0] link);
        mxt_st_t r;
        r = s;
        if (s.reh)
        begin
            r.reh = s.reh & ~auto_off;
        end
        else if (s.blk_armed && !s.blk_stage)
        begin
            r.blk_stage = 1'b1;
        end
        else
        begin
            if (s.sel[EL_BKGD])
            begin
                r.a_src = s.b_src;
                r.b_src = s.a_src;
            end
            r.key_on = s.key_on ^ s.sel[EL_KEY +: NKEY];
            if (s.sel[EL_ORDER])
            begin
                r.key_order = ord;
            end
            r.dsk_on = s.dsk_on ^ link;
            r.blk_armed = 1'b0;
            r.blk_stage = 1'b0;
        end
        r.complete = 1'b1;
        r.st = ST_IDLE;
        r.sync = 1'b0;
        return r;
    endfunction

    function automatic logic [2:0] first_set(input logic [NPVW-1:0] v);
        logic [2:0] r;
        r = '0;
        for (int i = NPVW - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    always_comb
    begin
        d = q;
        prog_load = 1'b0;
        prog_ld_pos = POS_ZERO;
        // Buttons and lever come from the panel: two flip-flops first.
        d.b1 = btn_raw;
        d.b2 = q.b1;
        d.b3 = q.b2;
        d.as1 = a_src_i;
        d.as2 = q.as1;
        d.bs1 = b_src_i;
        d.bs2 = q.bs1;
        d.lv1 = lever_pos_i;
        d.lv2 = q.lv1;
        rise = q.b2 & ~q.b3;
        lat_lo = (q.lv2 == POS_ZERO);
        lat_hi = (q.lv2 == POS_FULL);
        at_home = q.home ? lat_hi : lat_lo;
        at_far = q.home ? lat_lo : lat_hi;
        // Kept as off-limit so the cleared reset value cannot fake an arrival at a limit.
        d.lv_off = !(lat_lo | lat_hi);
        d.complete = 1'b0;
        d.kmx_go = '0;
        d.frame = (q.div == '0);
        d.div = (q.div == '0) ? DIV_LAST : q.div - DW'(1);
        if (q.frame && q.cut_cnt != '0)
        begin
            d.cut_cnt = q.cut_cnt - CUT_W'(1);
        end

        if (rise[BI_PVW +: NPVW] != '0)
        begin
            d.pvw = mxt_pvw_t'(first_set(rise[BI_PVW +: NPVW]));
        end

        for (int i = 0; i < NTT; i++)
        begin
            if (rise[BI_TT + i])
            begin
                d.ttype = mxt_ttype_t'(2'(i));
            end
        end

        if (q.st == ST_IDLE)
        begin
            for (int i = 0; i < NEL; i++)
            begin
                if (rise[BI_EL + i])
                begin
                    if ((q.b2[BI_EL +: NEL] & ~(NEL'(1) << i)) != '0)
                    begin
                        d.sel = d.sel | (NEL'(1) << i);
                    end
                    else
                    begin
                        d.sel = NEL'(1) << i;
                    end
                end
            end
            // A keyer mix is its own transition; it is blocked while the main
            // transition is really moving or while rehearsal is lit.
            for (int k = 0; k < NKEY; k++)
            begin
                if (rise[BI_KMX + k] && pos == POS_ZERO && !q.reh)
                begin
                    d.key_on[k] = ~d.key_on[k];
                    d.kmx_go[k] = 1'b1;
                end
            end
        end

        if (rise[BI_BPR])
        begin
            d.b_src = q.bs2;
        end

        if (rise[BI_RCL])
        begin
            d.sync = 1'b0;
        end
        else if (!q.sync && q.lv_off && (lat_lo | lat_hi) && q.st == ST_IDLE)
        begin
            d.sync = 1'b1;
            d.home = lat_hi;
        end

        case (q.st)
            ST_IDLE:
            begin
                if (rise[BI_AUTO])
                begin
                    d.st = ST_AUTO;
                end
                else if (q.sync && !at_home)
                begin
                    d.st = ST_LEVER;
                end
            end
            ST_LEVER:
            begin
                prog_load = 1'b1;
                prog_ld_pos = q.home ? POS_FULL - q.lv2 : q.lv2;
                if (rise[BI_AUTO])
                begin
                    prog_load = 1'b0;
                    d.st = ST_AUTO;
                    d.sync = 1'b0;
                end
                else if (at_far)
                begin
                    d = finish(d, reh_auto_off_i, new_key_order_i, dsk_link_i);
                    d.sync = 1'b1;
                    d.home = ~q.home;
                    prog_ld_pos = POS_ZERO;
                end
                else if (at_home)
                begin
                    d.st = ST_IDLE;
                    prog_ld_pos = POS_ZERO;
                end
            end
            ST_AUTO:
            begin
                if (prog_done)
                begin
                    d = finish(d, reh_auto_off_i, new_key_order_i, dsk_link_i);
                    prog_load = 1'b1;
                end
                else if (rise[BI_AUTO])
                begin
                    d.st = ST_PAUSE;
                end
            end
            ST_PAUSE:
            begin
                if (rise[BI_AUTO])
                begin
                    d.st = ST_AUTO;
                end
                else if (q.sync && at_far)
                begin
                    d = finish(d, reh_auto_off_i, new_key_order_i, dsk_link_i);
                    d.sync = 1'b1;
                    d.home = ~q.home;
                    prog_load = 1'b1;
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase

        if (rise[BI_CUT])
        begin
            d = finish(d, reh_auto_off_i, new_key_order_i, dsk_link_i);
            d.cut_cnt = CUT_W'(CUT_LAMP_FRAMES);
            d.sync = q.sync && q.st == ST_IDLE;
            prog_load = 1'b1;
            prog_ld_pos = POS_ZERO;
        end

        if (rise[BI_BLK] && !q.reh)
        begin
            if (q.blk_armed)
            begin
                // Nothing was applied at black, so dropping the flags restores
                // the original picture.
                d.blk_armed = 1'b0;
                d.blk_stage = 1'b0;
            end
            else
            begin
                d.blk_armed = 1'b1;
            end
        end

        if (rise[BI_APR])
        begin
            d.a_src = q.as2;
            if (q.blk_armed)
            begin
                d.key_on = '0;
                d.blk_armed = 1'b0;
                d.blk_stage = 1'b0;
                d.st = ST_IDLE;
                d.sync = 1'b0;
                prog_load = 1'b1;
                prog_ld_pos = POS_ZERO;
            end
        end

        if (rise[BI_REH])
        begin
            if (q.reh)
            begin
                d.reh = 1'b0;
                if (q.st == ST_AUTO || q.st == ST_PAUSE)
                begin
                    d.st = ST_IDLE;
                    d.sync = 1'b0;
                    prog_load = 1'b1;
                    prog_ld_pos = POS_ZERO;
                end
            end
            else if (q.st == ST_IDLE && pos == POS_ZERO && (lat_lo | lat_hi)
                     && !q.blk_armed)
            begin
                d.reh = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    mxt_prog #(
        .PW(POS_W),
        .RW(RATE_W)
    ) u_prog (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .frame_en_i(q.frame),
        .load_i(prog_load),
        .load_pos_i(prog_ld_pos),
        .run_i(q.st == ST_AUTO),
        .rate_i(rate_frames_i),
        .pos_o(pos),
        .done_o(prog_done)
    );

    assign pvw_lamp_o = NPVW'(1) << q.pvw;
    assign pvw_route_o = q.pvw;
    assign primary_xpt_high_o = pvw_delegated_i && q.pvw == PV_PRIMARY;
    assign elem_lamp_o = q.sel;
    assign type_lamp_o = NTT'(1) << q.ttype;
    assign cut_lamp_o = q.cut_cnt != '0;
    assign auto_lamp_o = q.st == ST_AUTO;
    assign black_lamp_o = q.blk_armed;
    assign rehearse_lamp_o = q.reh;
    // At black the lamps already show the keys after the second command.
    assign key_on_lamp_o = q.blk_stage ? q.key_on ^ q.sel[EL_KEY +: NKEY] : q.key_on;
    assign key_mix_go_o = q.kmx_go;
    assign arrow_up_o = q.sync ? ~q.home : (q.lv2 < POS_HALF);
    assign arrow_dn_o = q.sync ? q.home : (q.lv2 >= POS_HALF);
    assign a_src_o = q.a_src;
    assign b_src_o = q.b_src;
    assign ab_low_tally_o = q.blk_stage;
    assign pgm_black_o = q.blk_stage;
    assign key_state_o = q.key_on;
    assign key_order_o = q.key_order;
    assign dsk_on_o = q.dsk_on;
    assign pgm_pos_o = q.reh ? POS_ZERO : pos;
    assign pvw_pos_o = q.reh ? pos : POS_ZERO;
    assign pvw_override_o = q.reh;
    assign complete_o = q.complete;
endmodule // mxt_ctrl

// file: verification/mxt_ctrl_checker.sv
`timescale 1ns/100ps
module mxt_ctrl_checker
    import mxt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cut_btn_i,
    input wire logic black_btn_i,
    input wire logic pvw_delegated_i,
    input wire logic [NPVW-1:0] pvw_lamp_o,
    input wire logic primary_xpt_high_o,
    input wire logic [NEL-1:0] elem_lamp_o,
    input wire logic [NTT-1:0] type_lamp_o,
    input wire logic cut_lamp_o,
    input wire logic auto_lamp_o,
    input wire logic black_lamp_o,
    input wire logic rehearse_lamp_o,
    input wire logic [NKEY-1:0] key_mix_go_o,
    input wire logic [SRC_W-1:0] a_src_o,
    input wire logic [NKEY-1:0] key_state_o,
    input wire logic ab_low_tally_o,
    input wire logic [POS_W-1:0] pgm_pos_o,
    input wire logic complete_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_pvw_still;
        $stable(pvw_lamp_o) && $stable(pvw_delegated_i);
    endsequence
    sequence s_blk_arm;
        $rose(black_btn_i) && !black_lamp_o && !rehearse_lamp_o;
    endsequence
    property p_pvw_one;
        $onehot(pvw_lamp_o);
    endproperty
    a_pvw_one: assert property (p_pvw_one) else $error("preview lamps not one-hot");
    property p_prim;
        s_pvw_still ##1 s_pvw_still |-> primary_xpt_high_o == (pvw_delegated_i && pvw_lamp_o[0]);
    endproperty
    a_prim: assert property (p_prim) else $error("primary tally wrong");
    property p_type_one;
        $onehot(type_lamp_o);
    endproperty
    a_type_one: assert property (p_type_one) else $error("type lamps wrong");
    property p_type_still;
        $changed(type_lamp_o) |-> $stable(a_src_o) && $stable(key_state_o);
    endproperty
    a_type_still: assert property (p_type_still) else $error("type change moved output");
    property p_elem;
        $changed(elem_lamp_o) |-> $stable(a_src_o) && $stable(key_state_o);
    endproperty
    a_elem: assert property (p_elem) else $error("element change moved output");
    property p_cut;
        $rose(cut_btn_i) |-> ##[3:4] cut_lamp_o;
    endproperty
    a_cut: assert property (p_cut) else $error("cut lamp not lit");
    property p_cut_hold;
        $rose(cut_lamp_o) |-> cut_lamp_o [*8];
    endproperty
    a_cut_hold: assert property (p_cut_hold) else $error("cut lamp too short");
    property p_done;
        complete_o |=> !complete_o;
    endproperty
    a_done: assert property (p_done) else $error("completion not a pulse");
    property p_blk;
        s_blk_arm |-> ##[3:4] black_lamp_o;
    endproperty
    a_blk: assert property (p_blk) else $error("through-black not armed");
    property p_tally;
        ab_low_tally_o |-> black_lamp_o;
    endproperty
    a_tally: assert property (p_tally) else $error("low tally outside black");
    property p_reh;
        (black_lamp_o || auto_lamp_o) && !rehearse_lamp_o |=> !rehearse_lamp_o;
    endproperty
    a_reh: assert property (p_reh) else $error("rehearsal not refused");
    property p_reh_pgm;
        rehearse_lamp_o |-> pgm_pos_o == 16'h0000;
    endproperty
    a_reh_pgm: assert property (p_reh_pgm) else $error("program moved in rehearsal");
    property p_kmx;
        (|key_mix_go_o) |-> $past(pgm_pos_o) == 16'h0000;
    endproperty
    a_kmx: assert property (p_kmx) else $error("key mix during transition");
endmodule // mxt_ctrl_checker

bind mxt_ctrl mxt_ctrl_checker u_chk (.clk_i, .rstn_i, .cut_btn_i, .black_btn_i,
    .pvw_delegated_i, .pvw_lamp_o, .primary_xpt_high_o, .elem_lamp_o, .type_lamp_o,
    .cut_lamp_o, .auto_lamp_o, .black_lamp_o, .rehearse_lamp_o, .key_mix_go_o,
    .a_src_o, .key_state_o, .ab_low_tally_o, .pgm_pos_o, .complete_o);

// file: verification/mxt_panel.sv
`timescale 1ns/100ps
module mxt_panel
    import mxt_pkg::*;
#(
    parameter int HOLD = 4
)
(
    input wire logic clk_i,
    input wire logic [BTN_W-1:0] req_i,
    output logic [BTN_W-1:0] btn_o
);
    int cnt = 0;
    // A new request joins any held button, so chords keep the first one down.
    always @(posedge clk_i)
    begin
        if (req_i != '0)
        begin
            btn_o <= btn_o | req_i;
            cnt <= HOLD;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
        else
        begin
            btn_o <= '0;
            cnt <= 0;
        end
    end
endmodule // mxt_panel

// file: verification/tb_mxt_ctrl.sv
`timescale 1ns/100ps
module tb_mxt_ctrl;
    import mxt_pkg::*;
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [BTN_W-1:0] req = '0;
    logic [BTN_W-1:0] btn;
    logic [SRC_W-1:0] b_src = '0;
    logic [SRC_W-1:0] a_src = '0;
    logic dlg = 1'b1;
    logic [NKEY-1:0] kon;
    logic [RATE_W-1:0] rate = 10'h004;
    logic [2*SRC_W-1:0] q[$];
    logic [2*SRC_W-1:0] note;
    logic [SRC_W-1:0] ea = '0;
    logic [SRC_W-1:0] eb = '0;
    logic [POS_W-1:0] hold;
    logic [NPVW-1:0] pvw_lamp;
    logic [2:0] pvw_route;
    logic [NEL-1:0] elem_lamp;
    logic [NTT-1:0] type_lamp;
    logic [NKEY-1:0] key_state;
    logic [SRC_W-1:0] a_o, b_o;
    logic [POS_W-1:0] pgm_pos;
    logic pxh, cut_lamp, auto_lamp, black_lamp, reh_lamp, ab_low, pgm_black, pvw_ovr, complete;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    always #2.5 clk_i = ~clk_i;

    mxt_panel u_mxt_panel (.clk_i(clk_i), .req_i(req), .btn_o(btn));

    mxt_ctrl #(.FRAME_CYCLES(8)) u_mxt_ctrl (.clk_i(clk_i), .rstn_i(rstn_i),
        .elem_btn_i(btn[BI_EL+:NEL]), .type_btn_i(btn[BI_TT+:NTT]), .cut_btn_i(btn[BI_CUT]),
        .auto_btn_i(btn[BI_AUTO]), .black_btn_i(btn[BI_BLK]), .rehearse_btn_i(btn[BI_REH]),
        .key_mix_btn_i(btn[BI_KMX+:NKEY]), .pvw_btn_i(btn[BI_PVW+:NPVW]),
        .a_press_i(btn[BI_APR]), .a_src_i(a_src), .b_press_i(btn[BI_BPR]), .b_src_i(b_src),
        .recall_i(btn[BI_RCL]), .lever_pos_i('0), .pvw_delegated_i(dlg), .dsk_link_i('0),
        .reh_auto_off_i(1'b1), .new_key_order_i('0), .rate_frames_i(rate),
        .pvw_lamp_o(pvw_lamp), .pvw_route_o(pvw_route), .primary_xpt_high_o(pxh),
        .elem_lamp_o(elem_lamp), .type_lamp_o(type_lamp), .cut_lamp_o(cut_lamp),
        .auto_lamp_o(auto_lamp), .black_lamp_o(black_lamp), .rehearse_lamp_o(reh_lamp),
        .key_on_lamp_o(kon), .key_mix_go_o(), .arrow_up_o(), .arrow_dn_o(), .a_src_o(a_o),
        .b_src_o(b_o), .ab_low_tally_o(ab_low), .pgm_black_o(pgm_black),
        .key_state_o(key_state), .key_order_o(), .dsk_on_o(), .pgm_pos_o(pgm_pos),
        .pvw_pos_o(), .pvw_override_o(pvw_ovr), .complete_o(complete));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask

    task automatic press(input int b, input int w);
        req[b] <= 1'b1;
        @(posedge clk_i);
        req <= '0;
        repeat (w) @(posedge clk_i);
    endtask

    // Load a new B source, then queue the bus swap that the next completion must show.
    task automatic arm_swap;
        b_src <= 6'($urandom);
        press(BI_BPR, 10);
        eb = b_src;
        chk("b_src", 16'(eb), 16'(b_o));
        q.push_back({eb, ea});
        {ea, eb} = {eb, ea};
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(negedge clk_i)
    begin
        if (complete === 1'b1 && q.size() > 0)
        begin
            note = q.pop_front();
            chk("ab_src", 16'(note), 16'({a_o, b_o}));
        end
    end

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            close_out();
        end
    end

    initial
    begin
        void'($urandom(15632));
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk("pvw_lamp", 16'h0001, 16'(pvw_lamp));
        chk("elem_lamp", 16'h0000, 16'(elem_lamp));
        for (int i = 0; i < NPVW + 1; i++)
        begin
            dlg <= (i != NPVW);
            press(BI_PVW + (i % NPVW), 10);
            chk("pvw_lamp", 16'(1 << (i % NPVW)), 16'(pvw_lamp));
            chk("pvw_route", 16'(i % NPVW), 16'(pvw_route));
            chk("primary", 16'(i % NPVW == 0 && i != NPVW), 16'(pxh));
        end
        for (int j = NTT - 1; j >= 0; j--)
        begin
            press(BI_TT + j, 10);
            chk("type_lamp", 16'(1 << j), 16'(type_lamp));
        end
        press(BI_EL + 1, 10);
        press(BI_EL, 2);
        press(BI_EL + 2, 10);
        chk("elem_chord", 16'h0005, 16'(elem_lamp));
        press(BI_EL, 10);
        chk("elem_single", 16'h0001, 16'(elem_lamp));
        $display("test panel done");
        arm_swap();
        press(BI_CUT, 6);
        chk("cut_lamp", 16'h0001, 16'(cut_lamp));
        $display("test cut done");
        rate <= 10'(4 + $urandom % 4);
        arm_swap();
        press(BI_AUTO, 12);
        chk("auto_lamp", 16'h0001, 16'(auto_lamp));
        press(BI_AUTO, 6);
        hold = pgm_pos;
        repeat (24) @(posedge clk_i);
        chk("paused_pos", 16'(hold), 16'(pgm_pos));
        press(BI_AUTO, 0);
        for (int k = 0; k < 2000 && complete !== 1'b1; k++) @(negedge clk_i);
        repeat (4) @(posedge clk_i);
        chk("auto_off", 16'h0000, 16'(auto_lamp));
        $display("test auto done");
        press(BI_BLK, 10);
        chk("black_lamp", 16'h0001, 16'(black_lamp));
        press(BI_CUT, 10);
        chk("ab_low", 16'h0001, 16'(ab_low));
        chk("pgm_black", 16'h0001, 16'(pgm_black));
        chk("a_held", 16'(ea), 16'(a_o));
        press(BI_REH, 10);
        chk("reh_refused", 16'h0000, 16'(reh_lamp));
        arm_swap();
        press(BI_CUT, 10);
        chk("black_clear", 16'h0000, 16'(black_lamp));
        $display("test black done");
        press(BI_REH, 10);
        chk("reh_lamp", 16'h0001, 16'(reh_lamp));
        chk("pvw_override", 16'h0001, 16'(pvw_ovr));
        press(BI_AUTO, 10);
        for (int k = 0; k < 2000 && reh_lamp === 1'b1; k++) @(negedge clk_i);
        @(posedge clk_i);
        chk("reh_a", 16'(ea), 16'(a_o));
        chk("reh_off", 16'h0000, 16'(reh_lamp));
        press(BI_KMX, 10);
        chk("key_mix", 16'h0001, 16'(key_state));
        chk("key_on_lamp", 16'h0001, 16'(kon));
        press(BI_BLK, 10);
        a_src <= 6'($urandom);
        press(BI_APR, 10);
        chk("a_press", 16'(a_src), 16'(a_o));
        chk("keys_dropped", 16'h0000, 16'(key_state));
        chk("black_cancel", 16'h0000, 16'(black_lamp));
        chk("notes_left", 16'h0000, 16'(q.size()));
        $display("test rehearse done");
        close_out();
    end
endmodule // tb_mxt_ctrl
